// *** pdpc_host_model.sv ***
// Host model that programs the configuration image over APB.
`timescale 1ns/1ps
module pdpc_host_model
    import pdpc_pkg::*;
(
    input  wire logic                        clk_sys,
    output logic      [pdpc_pkg::ADDR_W-1:0] paddr,
    output logic                             psel,
    output logic                             penable,
    output logic                             pwrite,
    output logic      [31:0]                 pwdata,
    output logic      [3:0]                  pstrb,
    input  wire logic [31:0]                 prdata,
    input  wire logic                        pready,
    input  wire logic                        pslverr
);
    import pdpc_pkg::*;

    // Image bit 93 is reserved, so the host always clears it in word two.
    localparam logic [31:0] RSV_W2 = 32'h2000_0000;
    logic [31:0] rd_data;
    logic        rd_err;

    initial begin
        paddr = 8'h00;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        pwdata = 32'h0;
        pstrb = 4'h0;
    end

    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        input logic [3:0] s);
        @(posedge clk_sys);
        paddr   <= a;
        pwrite  <= wr;
        pwdata  <= (a == 8'h08) ? (d & ~RSV_W2) : d;
        pstrb   <= wr ? s : 4'h0;
        psel    <= 1'b1;
        penable <= 1'b0;
        @(posedge clk_sys);
        penable <= 1'b1;
        do @(posedge clk_sys); while (pready !== 1'b1);
        rd_data = prdata;
        rd_err  = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask
endmodule

// *** pdpc_outdiv.sv ***
// One output divider producing a one-cycle tick every modulus cycles.
`timescale 1ns/1ps
module pdpc_outdiv
    import pdpc_pkg::*;
(
    input  wire logic     clk_sys,
    input  wire logic     rst_n,
    pdpc_outdiv_if.div    port
);
    import pdpc_pkg::*;

    logic [5:0] cnt;
    logic [5:0] next_cnt;
    wire  [5:0] mod_now = pdpc_modulus(port.code);
    wire        at_end  = (cnt >= mod_now - 6'h01);

    // A code change may leave the count beyond the new end; the compare wraps it at once.
    assign next_cnt = at_end ? 6'h00 : cnt + 6'h01;

    always_ff @(posedge clk_sys) begin
        if (!rst_n || port.off) begin
            cnt       <= 6'h00;
            port.tick <= 1'b0;
        end else begin
            cnt       <= next_cnt;
            port.tick <= at_end;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            port.modulus <= 6'h01;
        end else begin
            port.modulus <= mod_now;
        end
    end

    property p_off_quiet;
        @(posedge clk_sys) disable iff (!rst_n) port.off |=> !port.tick;
    endproperty
    a_off_quiet: assert property (p_off_quiet) else $error("Divider ticks while powered down.");

    property p_div2_period;
        @(posedge clk_sys) disable iff (!rst_n)
            (port.tick && port.code == 4'h1 && !port.off)[*1] ##1
            ($stable(port.code) && !port.off) |-> !port.tick ##1 (port.tick || port.off);
    endproperty
    a_div2_period: assert property (p_div2_period) else $error("Divide-by-two tick spacing wrong.");

    c_tick: cover property (@(posedge clk_sys) disable iff (!rst_n) port.tick && port.code == 4'hF);
endmodule

// *** pdpc_outdiv_if.sv ***
// Interface between the configuration core and one output divider.
`timescale 1ns/1ps
interface pdpc_outdiv_if;
    logic [3:0] code;
    logic       off;
    logic       tick;
    logic [5:0] modulus;

    modport ctrl (output code, output off, input tick, input modulus);
    modport div  (input code, input off, output tick, output modulus);
endinterface

// *** pdpc_pkg.sv ***
// Package with the image layout, register offsets and divider tables of the clock configuration.
package pdpc_pkg;

    localparam int             IMG_W    = 128;
    localparam logic [127:0]   IMG_RST  = 128'h0;
    localparam int             ADDR_W   = 8;
    localparam int             REF_W    = 8;
    localparam int             FB_W     = 11;
    localparam int             ACNT_W   = 3;
    localparam int             MCNT_W   = 8;
    localparam int             CODE_W   = 4;
    localparam int             MOD_W    = 6;

    // Register offsets: four image words, then one read-only status word.
    localparam logic [7:0]     OFS_IMG0 = 8'h00;
    localparam logic [7:0]     OFS_IMG3 = 8'h0C;
    localparam logic [7:0]     OFS_STAT = 8'h10;

    // Bit positions inside the 128-bit image.
    localparam int             POS_PLL_OFF_A = 21;
    localparam int             POS_PLL_OFF_B = 45;
    localparam int             POS_PLL_OFF_C = 69;
    localparam int             POS_DIV_OFF_A = 120;
    localparam int             POS_DIV_OFF_B = 121;
    localparam int             POS_DIV_OFF_C = 122;
    localparam int             POS_DIV_OFF_D = 123;
    localparam int             POS_REF_A     = 0;
    localparam int             POS_REF_B     = 24;
    localparam int             POS_REF_C0    = 48;
    localparam int             POS_REF_C1    = 72;
    localparam int             POS_FB_A      = 8;
    localparam int             POS_FB_B      = 32;
    localparam int             POS_FB_C0     = 56;
    localparam int             POS_FB_C1     = 80;
    localparam int             POS_POST_A    = 96;
    localparam int             POS_POST_B    = 100;
    localparam int             POS_POST_C0   = 104;
    localparam int             POS_POST_D0   = 108;
    localparam int             POS_OUTDIV_C_CODE_SET0   = 112;
    localparam int             POS_OUTDIV_D_CODE_SET0   = 116;

    // Status word layout.
    localparam int             ST_PLL_OFF    = 0;
    localparam int             ST_DIV_OFF    = 3;
    localparam int             ST_PD_PIN     = 7;
    localparam int             ST_SEL_PIN    = 8;

    function automatic logic [5:0] pdpc_modulus(input logic [3:0] code);
        logic [5:0] m;
        m = 6'h01;
        case (code)
            4'h0:    m = 6'h01;
            4'h1:    m = 6'h02;
            4'h2:    m = 6'h03;
            4'h3:    m = 6'h04;
            4'h4:    m = 6'h05;
            4'h5:    m = 6'h06;
            4'h6:    m = 6'h08;
            4'h7:    m = 6'h09;
            4'h8:    m = 6'h0A;
            4'h9:    m = 6'h0C;
            4'hA:    m = 6'h0F;
            4'hB:    m = 6'h10;
            4'hC:    m = 6'h12;
            4'hD:    m = 6'h14;
            4'hE:    m = 6'h19;
            default: m = 6'h32;
        endcase
        return m;
    endfunction

endpackage

// *** pdpc_top.sv ***
// Configuration core: APB-held 128-bit image decoded into PLL and output divider settings.
//
// What this block does
// - Image bits 21, 45, 69 select PLL A, B, C for power-off.
// - Image bits 120 and 121 select output dividers A and B for power-off.
// - Selected parts power down only while the power-down pin is high.
// - PLL A input divisor is bits 7-0, PLL B bits 31-24.
// - PLL C input divisor is bits 55-48, or 79-72 with select high.
// - Loop divisor low three bits load A-counter, high eight the M-counter.
// - PLL C loop divisor is bits 66-56, or 90-80 with select high.
// - Output A code is bits 99-96, output B bits 103-100.
// - Output C code is bits 107-104, or 115-112 with select high.
// - Output D code is bits 111-108, or 119-116 with select high.
// - Codes 0-5 divide by 1-6, then 8,9,10,12,15,16,18,20,25,50.
// - The whole image is cleared to zero at reset.
// - Each written byte takes effect on its own, at its own write.
//
// The register offsets and the APB register port were chosen for this implementation.
`timescale 1ns/1ps
module pdpc_top
    import pdpc_pkg::*;
(
    input  wire logic                     clk_sys,
    input  wire logic                     rst_n,
    input  wire logic [pdpc_pkg::ADDR_W-1:0] paddr,
    input  wire logic                     psel,
    input  wire logic                     penable,
    input  wire logic                     pwrite,
    input  wire logic [31:0]              pwdata,
    input  wire logic [3:0]               pstrb,
    output logic      [31:0]              prdata,
    output logic                          pready,
    output logic                          pslverr,
    input  wire logic                     powerdown_pin,
    input  wire logic                     alt_set_select_pin,
    output logic      [2:0][7:0]          pll_input_divisor,
    output logic      [2:0][2:0]          pll_a_count,
    output logic      [2:0][7:0]          pll_m_count,
    output logic      [2:0]               pll_off,
    output logic      [3:0]               outdiv_off,
    output logic      [3:0][3:0]          outdiv_code,
    output logic      [3:0][5:0]          outdiv_modulus,
    output logic      [3:0]               outdiv_tick
);
    import pdpc_pkg::*;

    logic [IMG_W-1:0] image;
    logic [IMG_W-1:0] next_image;

    // Bus decode.
    wire       access   = psel & penable;
    wire       setup    = psel & ~penable;
    wire       hit_img  = (paddr <= OFS_IMG3) && (paddr[1:0] == 2'h0);
    wire       hit_stat = (paddr == OFS_STAT);
    wire       bad_addr = !(hit_img || (hit_stat && !pwrite));
    wire       wr_img   = access & pwrite & hit_img;
    wire [1:0] word_idx = paddr[3:2];
    wire [31:0] img_word = image[word_idx*32 +: 32];
    wire       sel      = alt_set_select_pin;

    wire [31:0] stat_word = {23'h0, alt_set_select_pin, powerdown_pin, outdiv_off, pll_off};
    wire [31:0] rd_mux    = hit_img ? img_word : (hit_stat ? stat_word : 32'h0);

    assign pready  = 1'b1;
    assign pslverr = access & bad_addr;

    // Each strobed byte lands on its own; there is no staging of a whole word.
    always_comb begin
        next_image = image;
        for (int b = 0; b < 4; b++) begin
            if (wr_img && pstrb[b]) begin
                next_image[word_idx*32 + b*8 +: 8] = pwdata[b*8 +: 8];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            image <= IMG_RST;
        end else begin
            image <= next_image;
        end
    end

    // Read data is captured in the setup cycle so the zero-wait access phase sees a flop.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            prdata <= 32'h0;
        end else if (setup) begin
            prdata <= pwrite ? 32'h0 : rd_mux;
        end
    end

    // Selected field views.
    wire [7:0]  ref_c  = sel ? image[POS_REF_C1 +: REF_W] : image[POS_REF_C0 +: REF_W];
    wire [10:0] fb_a   = image[POS_FB_A +: FB_W];
    wire [10:0] fb_b   = image[POS_FB_B +: FB_W];
    wire [10:0] fb_c   = sel ? image[POS_FB_C1 +: FB_W] : image[POS_FB_C0 +: FB_W];
    wire [3:0]  code_c = sel ? image[POS_OUTDIV_C_CODE_SET0 +: CODE_W] : image[POS_POST_C0 +: CODE_W];
    wire [3:0]  code_d = sel ? image[POS_OUTDIV_D_CODE_SET0 +: CODE_W] : image[POS_POST_D0 +: CODE_W];

    wire [2:0] pll_sel = {image[POS_PLL_OFF_C], image[POS_PLL_OFF_B], image[POS_PLL_OFF_A]};
    wire [3:0] div_sel = {image[POS_DIV_OFF_D], image[POS_DIV_OFF_C],
                          image[POS_DIV_OFF_B], image[POS_DIV_OFF_A]};

    // The enable bits only pick targets; the pin does the switching.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pll_off    <= 3'h0;
            outdiv_off <= 4'h0;
        end else begin
            pll_off    <= pll_sel & {3{powerdown_pin}};
            outdiv_off <= div_sel & {4{powerdown_pin}};
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            pll_input_divisor <= '0;
            pll_a_count       <= '0;
            pll_m_count       <= '0;
            outdiv_code       <= '0;
        end else begin
            pll_input_divisor <= {ref_c, image[POS_REF_B +: REF_W], image[POS_REF_A +: REF_W]};
            pll_a_count       <= {fb_c[2:0], fb_b[2:0], fb_a[2:0]};
            pll_m_count       <= {fb_c[10:3], fb_b[10:3], fb_a[10:3]};
            outdiv_code       <= {code_d, code_c, image[POS_POST_B +: CODE_W],
                                  image[POS_POST_A +: CODE_W]};
        end
    end

    // Four identical output dividers.
    for (genvar g = 0; g < 4; g++) begin : g_div
        pdpc_outdiv_if u_if ();
        assign u_if.code         = outdiv_code[g];
        assign u_if.off          = outdiv_off[g];
        assign outdiv_tick[g]    = u_if.tick;
        assign outdiv_modulus[g] = u_if.modulus;
        pdpc_outdiv u_div (
            .clk_sys (clk_sys),
            .rst_n   (rst_n),
            .port    (u_if.div)
        );
    end

    // Checks.
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    property p_reset_clear;
        $rose(rst_n) |-> (image == IMG_RST) && (pll_off == 3'h0) && (outdiv_tick == 4'h0);
    endproperty
    a_reset_clear: assert property (p_reset_clear) else $error("Image not clear after reset.");

    property p_pin_gate;
        !powerdown_pin ##1 !powerdown_pin |-> (pll_off == 3'h0) && (outdiv_off == 4'h0);
    endproperty
    a_pin_gate: assert property (p_pin_gate) else $error("Power-down without pin.");

    property p_pll_a_off;
        (powerdown_pin && image[POS_PLL_OFF_A]) |=> pll_off[0];
    endproperty
    a_pll_a_off: assert property (p_pll_a_off) else $error("PLL A not powered off.");

    property p_div_b_off;
        (powerdown_pin && image[POS_DIV_OFF_B]) |=> outdiv_off[1] ##1 !outdiv_tick[1];
    endproperty
    a_div_b_off: assert property (p_div_b_off) else $error("Divider B not powered off.");

    property p_byte_write;
        (access && pwrite && paddr == OFS_IMG0 && pstrb == 4'h1)
            |=> image[7:0] == $past(pwdata[7:0]) && $stable(image[31:8]);
    endproperty
    a_byte_write: assert property (p_byte_write) else $error("Byte write not applied alone.");

    property p_ref_ab;
        1'b1 |=> pll_input_divisor[0] == $past(image[7:0])
              && pll_input_divisor[1] == $past(image[31:24]);
    endproperty
    a_ref_ab: assert property (p_ref_ab) else $error("PLL A or B input divisor wrong.");

    property p_ref_c_sel;
        alt_set_select_pin |=> pll_input_divisor[2] == $past(image[79:72]);
    endproperty
    a_ref_c_sel: assert property (p_ref_c_sel) else $error("PLL C set-one divisor wrong.");

    property p_fb_split;
        !alt_set_select_pin |=> pll_m_count[2] == $past(image[66:59])
                             && pll_a_count[2] == $past(image[58:56])
                             && pll_m_count[0] == $past(image[18:11]);
    endproperty
    a_fb_split: assert property (p_fb_split) else $error("Loop divisor split wrong.");

    property p_code_d;
        alt_set_select_pin |=> outdiv_code[3] == $past(image[119:116]);
    endproperty
    a_code_d: assert property (p_code_d) else $error("Output D set-one code wrong.");

    property p_code_c;
        !alt_set_select_pin |=> outdiv_code[2] == $past(image[107:104]);
    endproperty
    a_code_c: assert property (p_code_c) else $error("Output C set-zero code wrong.");

    property p_mod_50;
        (outdiv_code[0] == 4'hF) ##1 (outdiv_code[0] == 4'hF) |-> outdiv_modulus[0] == 6'h32;
    endproperty
    a_mod_50: assert property (p_mod_50) else $error("Code 15 not divide by 50.");

    property p_pll_b_off;
        (powerdown_pin && image[POS_PLL_OFF_B]) |=> pll_off[1];
    endproperty
    a_pll_b_off: assert property (p_pll_b_off) else $error("PLL B not powered off.");

    property p_pll_c_off;
        (powerdown_pin && image[POS_PLL_OFF_C]) |=> pll_off[2];
    endproperty
    a_pll_c_off: assert property (p_pll_c_off) else $error("PLL C not powered off.");

    property p_pll_keep_on;
        (pll_sel == 3'h0) |=> (pll_off == 3'h0);
    endproperty
    a_pll_keep_on: assert property (p_pll_keep_on) else $error("Unselected PLL off.");

    property p_div_a_off;
        (powerdown_pin && image[POS_DIV_OFF_A]) |=> outdiv_off[0] ##1 !outdiv_tick[0];
    endproperty
    a_div_a_off: assert property (p_div_a_off) else $error("Divider A not powered off.");

    property p_div_keep_on;
        (div_sel == 4'h0) |=> (outdiv_off == 4'h0);
    endproperty
    a_div_keep_on: assert property (p_div_keep_on) else $error("Unselected divider off.");

    property p_pin_selects;
        (powerdown_pin && pll_sel == 3'h7) |=> (pll_off == 3'h7);
    endproperty
    a_pin_selects: assert property (p_pin_selects) else $error("Pin did not power off.");

    property p_ref_c_set0;
        !alt_set_select_pin |=> pll_input_divisor[2] == $past(image[55:48]);
    endproperty
    a_ref_c_set0: assert property (p_ref_c_set0) else $error("PLL C set-zero divisor wrong.");

    property p_fb_b;
        1'b1 |=> {pll_m_count[1], pll_a_count[1]} == $past(image[42:32]);
    endproperty
    a_fb_b: assert property (p_fb_b) else $error("PLL B loop divisor wrong.");

    property p_fb_c_set1;
        alt_set_select_pin |=> {pll_m_count[2], pll_a_count[2]} == $past(image[90:80]);
    endproperty
    a_fb_c_set1: assert property (p_fb_c_set1) else $error("PLL C set-one loop wrong.");

    property p_code_ab;
        1'b1 |=> outdiv_code[0] == $past(image[99:96])
              && outdiv_code[1] == $past(image[103:100]);
    endproperty
    a_code_ab: assert property (p_code_ab) else $error("Output A or B code wrong.");

    property p_code_c_set1;
        alt_set_select_pin |=> outdiv_code[2] == $past(image[115:112]);
    endproperty
    a_code_c_set1: assert property (p_code_c_set1) else $error("Output C set-one wrong.");

    property p_code_d_set0;
        !alt_set_select_pin |=> outdiv_code[3] == $past(image[111:108]);
    endproperty
    a_code_d_set0: assert property (p_code_d_set0) else $error("Output D set-zero wrong.");

    property p_mod_1;
        (outdiv_code[1] == 4'h0) ##1 (outdiv_code[1] == 4'h0) |-> outdiv_modulus[1] == 6'h01;
    endproperty
    a_mod_1: assert property (p_mod_1) else $error("Code 0 not divide by 1.");

    property p_mod_2;
        (outdiv_code[0] == 4'h1) ##1 (outdiv_code[0] == 4'h1) |-> outdiv_modulus[0] == 6'h02;
    endproperty
    a_mod_2: assert property (p_mod_2) else $error("Code 1 not divide by 2.");

    // Bus checks: refused accesses answer with an error; word zero answers without one and reads back.
    property p_bad_addr;
        (access && paddr > OFS_STAT) |-> pslverr;
    endproperty
    a_bad_addr: assert property (p_bad_addr) else $error("Unmapped access not refused.");

    property p_stat_write_err;
        (access && pwrite && paddr == OFS_STAT) |-> pslverr;
    endproperty
    a_stat_write_err: assert property (p_stat_write_err) else $error("Status write not refused.");

    property p_img_no_err;
        (access && paddr == OFS_IMG0) |-> !pslverr;
    endproperty
    a_img_no_err: assert property (p_img_no_err) else $error("Image access refused.");

    property p_read_data;
        (setup && !pwrite && paddr == OFS_IMG0) |=> prdata == $past(image[31:0]);
    endproperty
    a_read_data: assert property (p_read_data) else $error("Word zero read data wrong.");

    c_img_write: cover property (wr_img && pstrb == 4'hF);
    c_pd_active: cover property (powerdown_pin && pll_off == 3'h7);
    c_alt_set:   cover property (alt_set_select_pin && outdiv_tick[2]);
    c_bad_addr:  cover property (pslverr);
endmodule

// *** pdpc_top_test.sv ***
// Self-checking testbench of the clock configuration core.
`timescale 1ns/1ps
module pdpc_top_test;
    import pdpc_pkg::*;
    typedef struct {logic [127:0] img; logic sel;} pdpc_row_t;
    logic            clk_sys, rst_n, powerdown_pin, alt_set_select_pin;
    logic [7:0]      paddr;
    logic            psel, penable, pwrite, pready, pslverr;
    logic [31:0]     pwdata, prdata;
    logic [3:0]      pstrb, outdiv_off, outdiv_tick;
    logic [2:0][7:0] pll_input_divisor, pll_m_count;
    logic [2:0][2:0] pll_a_count;
    logic [2:0]      pll_off;
    logic [3:0][3:0] outdiv_code;
    logic [3:0][5:0] outdiv_modulus;
    int              n_fail, n_tests, cyc;
    logic [5:0] mod_tab [16] = '{6'h01, 6'h02, 6'h03, 6'h04, 6'h05, 6'h06, 6'h08, 6'h09,
                                 6'h0A, 6'h0C, 6'h0F, 6'h10, 6'h12, 6'h14, 6'h19, 6'h32};
    localparam logic [127:0] IMG_X = 128'h0FA5_7E39_1DB6_4C21_9F5B_3A78_1254_2BCD;
    localparam logic [127:0] IMG_Y = 128'h0C3E_91D7_0A6F_B512_E4C8_5D93_7A0E_C614;
    pdpc_row_t rows [4] = '{'{IMG_X, 1'b0}, '{IMG_X, 1'b1}, '{IMG_Y, 1'b0}, '{IMG_Y, 1'b1}};

    pdpc_top i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .powerdown_pin(powerdown_pin),
        .alt_set_select_pin(alt_set_select_pin), .pll_input_divisor(pll_input_divisor),
        .pll_a_count(pll_a_count), .pll_m_count(pll_m_count), .pll_off(pll_off),
        .outdiv_off(outdiv_off), .outdiv_code(outdiv_code), .outdiv_modulus(outdiv_modulus),
        .outdiv_tick(outdiv_tick));
    pdpc_host_model i_host (.clk_sys(clk_sys), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    initial begin
        clk_sys = 1'b0;
        forever #50 clk_sys = ~clk_sys;
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
        n_tests++;
        if (got !== exp) begin
            n_fail++;
            $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic settle(input int n);
        repeat (n) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask

    task automatic chk_row(input logic [127:0] m, input logic s);
        logic [3:0] ec [4];
        ec = '{m[99:96], m[103:100], s ? m[115:112] : m[107:104], s ? m[119:116] : m[111:108]};
        chk(32'(pll_input_divisor[0]), 32'(m[7:0]), "ref a");
        chk(32'(pll_input_divisor[1]), 32'(m[31:24]), "ref b");
        chk(32'(pll_input_divisor[2]), 32'(s ? m[79:72] : m[55:48]), "ref c");
        chk(32'({pll_m_count[0], pll_a_count[0]}), 32'(m[18:8]), "loop a");
        chk(32'({pll_m_count[1], pll_a_count[1]}), 32'(m[42:32]), "loop b");
        chk(32'({pll_m_count[2], pll_a_count[2]}), 32'(s ? m[90:80] : m[66:56]), "loop c");
        for (int i = 0; i < 4; i++) begin
            chk(32'(outdiv_code[i]), 32'(ec[i]), "code");
            chk(32'(outdiv_modulus[i]), 32'(mod_tab[ec[i]]), "modulus");
        end
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            end_sim();
        end
    end

    initial begin
        rst_n = 1'b0;
        powerdown_pin = 1'b0;
        alt_set_select_pin = 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        settle(0);
        chk_row(128'h0, 1'b0);
        chk(32'(pll_off), 32'h0, "off at reset");
        foreach (rows[r]) begin
            for (int k = 0; k < 4; k++) i_host.xfer(1'b1, 8'(4 * k), rows[r].img[32*k +: 32], 4'hF);
            alt_set_select_pin <= rows[r].sel;
            settle(3);
            chk_row(rows[r].img, rows[r].sel);
        end
        for (int k = 0; k < 16; k++) begin
            i_host.xfer(1'b1, 8'h0C, {24'hFFFFFF, 4'(15 - k), 4'(k)}, 4'h1);
            settle(3);
            chk(32'(outdiv_modulus[0]), 32'(mod_tab[k]), "modulus a");
            chk(32'(outdiv_modulus[1]), 32'(mod_tab[15 - k]), "modulus b");
        end
        chk(32'(outdiv_code[2]), 32'(IMG_Y[115:112]), "unstrobed byte");
        i_host.xfer(1'b1, 8'h00, 32'hFFFF_FF5A, 4'h1);
        i_host.xfer(1'b0, 8'h00, 32'h0, 4'h0);
        chk(i_host.rd_data, {IMG_Y[31:8], 8'h5A}, "byte lane");
        i_host.xfer(1'b1, 8'h00, 32'h0020_0000, 4'hF);
        i_host.xfer(1'b1, 8'h04, 32'h0000_2000, 4'hF);
        i_host.xfer(1'b1, 8'h08, 32'h2000_0020, 4'hF);
        i_host.xfer(1'b1, 8'h0C, 32'h0300_0000, 4'hF);
        settle(3);
        chk(32'({outdiv_off, pll_off}), 32'h0, "off without pin");
        @(posedge clk_sys);
        powerdown_pin <= 1'b1;
        settle(3);
        chk(32'(pll_off), 32'h7, "pll off");
        chk(32'(outdiv_off), 32'h3, "divider off");
        repeat (4) begin
            settle(0);
            chk(32'(outdiv_tick[2:0]), 32'h4, "ticks while off");
        end
        i_host.xfer(1'b0, 8'h10, 32'h0, 4'h0);
        chk(i_host.rd_data, 32'h0000_019F, "status");
        powerdown_pin <= 1'b0;
        settle(3);
        chk(32'({outdiv_off, pll_off}), 32'h0, "pin released");
        i_host.xfer(1'b0, 8'h14, 32'h0, 4'h0);
        chk({31'h0, i_host.rd_err}, 32'h1, "unmapped error");
        chk(i_host.rd_data, 32'h0, "unmapped data");
        i_host.xfer(1'b1, 8'h10, 32'hFFFF_FFFF, 4'hF);
        chk({31'h0, i_host.rd_err}, 32'h1, "status write error");
        i_host.xfer(1'b0, 8'h08, 32'h0, 4'h0);
        chk(i_host.rd_data, 32'h0000_0020, "reserved bit clear");
        @(posedge clk_sys);
        rst_n <= 1'b0;
        repeat (2) @(posedge clk_sys);
        rst_n <= 1'b1;
        i_host.xfer(1'b0, 8'h04, 32'h0, 4'h0);
        chk(i_host.rd_data, 32'h0, "image after reset");
        end_sim();
    end
endmodule
